// ===== hw/pmrc_defines.svh
// Constants for the power-mode and reset control block
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH
`define PMRC_ADDR_POWER_MODE_CONTROL 8'h87
`define PMRC_PMC_RESET 8'h00
`define PMRC_BIT_IDLE 0
`define PMRC_BIT_STOP 1
`define PMRC_FLAGS_LSB 2
`define PMRC_PORT_LATCH_RESET 8'hff
`define PMRC_SP_RESET 8'h07
`define PMRC_PC_RESET 16'h0000
`define PMRC_WDT_DIV 12
`define PMRC_CLK_NS 10
`define PMRC_POR_DELAY_US 300
`define PMRC_POR_DELAY_CYC ((`PMRC_POR_DELAY_US * 1000) / `PMRC_CLK_NS)
`endif

// ===== hw/pmrc_pkg.sv
// Types for the power-mode and reset control block
package pmrc_pkg;
	typedef enum logic [1:0] {PMRC_ST_POR, PMRC_ST_RESET, PMRC_ST_RUN} pmrc_seq_e;
	typedef enum logic [1:0] {PMRC_PM_ACTIVE, PMRC_PM_IDLE, PMRC_PM_STOP} pmrc_mode_e;
endpackage

// ===== hw/pmrc_power_mode_reset_control.sv
// Power-mode control and reset sequencing for the core
`timescale 1ns/1ps
`default_nettype none
`include "pmrc_defines.svh"

// Notes on behaviour
// - Six free software flags in upper bits
// - Stop bit enters stop, reads zero
// - Idle halts core, clocks run, after instruction
// - Enabled interrupt or reset ends idle
// - Stop halts oscillator; only reset ends it
// - Reset halts core, resets registers, ports, interrupts
// - Data memory untouched by any reset
// - Stack pointer reloads on every reset
// - Port latches all ones, pull-ups kept
// - Reset pin driven low for monitor/power-on
// - Leaving reset clears PC, selects internal oscillator
// - Watchdog enabled, clocked at sysclk over twelve
// - Fetch starts at address zero always
// - Held in reset until supply above threshold
// - Wait power-on delay before release
// - Power-on exit sets power-on flag
// - Other resets clear power-on flag
// - Supply monitor enabled after power-on reset
// - Stop entered after setting instruction completes
module pmrc_power_mode_reset_control #(
	parameter int unsigned POR_DELAY_CYC = `PMRC_POR_DELAY_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic supply_ok,
	input wire logic other_reset,
	input wire logic monitor_reset,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic instr_done,
	input wire logic irq_pending,
	output logic [7:0] sfr_rdata,
	output logic core_halt,
	output logic core_reset,
	output logic osc_run,
	output logic periph_run,
	output logic irq_timer_enable,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic [7:0] port_latch,
	output logic port_open_drain,
	output logic weak_pullup_en,
	output logic [7:0] stack_pointer,
	output logic [15:0] fetch_addr,
	output logic sysclk_internal,
	output logic wdt_enable,
	output logic [3:0] wdt_div_count,
	output logic wdt_tick,
	output logic power_on_reset_flag,
	output logic supply_monitor_en,
	output pmrc_pkg::pmrc_mode_e power_mode
);
	import pmrc_pkg::*;

	pmrc_seq_e seq; // Reset sequencer state
	logic [5:0] general_purpose_flags; // Software-only flags, no effect
	logic idle_req; // Idle bit written, waiting for instruction end
	logic stop_req; // Stop bit written, waiting for instruction end
	logic [31:0] por_count; // Power-on release delay counter
	logic pmc_hit; // Access targets the power mode control register
	logic in_reset; // Sequencer holds core in reset

	assign pmc_hit = (sfr_addr == `PMRC_ADDR_POWER_MODE_CONTROL);
	assign in_reset = (seq != PMRC_ST_RUN);

	// Reset sequencer; supply loss restarts the full power-on path
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			seq <= PMRC_ST_POR;
			por_count <= 32'h0;
		end
		else if (!supply_ok)
		begin
			seq <= PMRC_ST_POR;
			por_count <= 32'h0;
		end
		else if (seq == PMRC_ST_POR)
		begin
			// Delay counted only while supply is above threshold
			if (por_count >= POR_DELAY_CYC - 1)
				seq <= PMRC_ST_RUN;
			else
				por_count <= por_count + 32'h1;
		end
		else if (monitor_reset || other_reset)
			seq <= PMRC_ST_RESET;
		else
			seq <= PMRC_ST_RUN;
	end

	// Power-on flag and supply monitor state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			power_on_reset_flag <= 1'b0;
			supply_monitor_en <= 1'b0;
		end
		else if (seq == PMRC_ST_POR)
		begin
			power_on_reset_flag <= 1'b1;
			supply_monitor_en <= 1'b1;
		end
		else if (monitor_reset || other_reset)
			power_on_reset_flag <= 1'b0;
	end

	// Software register; idle/stop are write-only strobes
	always_ff @(posedge clk)
	begin
		if (rst || in_reset)
		begin
			general_purpose_flags <= 6'(`PMRC_PMC_RESET >> `PMRC_FLAGS_LSB);
			idle_req <= 1'b0;
			stop_req <= 1'b0;
		end
		else
		begin
			if (sfr_wr && pmc_hit)
			begin
				general_purpose_flags <= sfr_wdata[7:`PMRC_FLAGS_LSB];
				idle_req <= sfr_wdata[`PMRC_BIT_IDLE];
				stop_req <= sfr_wdata[`PMRC_BIT_STOP];
			end
			else if (instr_done)
			begin
				idle_req <= 1'b0;
				stop_req <= 1'b0;
			end
		end
	end

	// Power mode; entry waits for the setting instruction to complete
	always_ff @(posedge clk)
	begin
		if (rst || in_reset)
			power_mode <= PMRC_PM_ACTIVE;
		else
		begin
			unique case (power_mode)
				PMRC_PM_ACTIVE:
				begin
					if (instr_done && stop_req)
						power_mode <= PMRC_PM_STOP;
					else if (instr_done && idle_req)
						power_mode <= PMRC_PM_IDLE;
				end
				PMRC_PM_IDLE:
				begin
					if (irq_pending)
						power_mode <= PMRC_PM_ACTIVE;
				end
				PMRC_PM_STOP:
					power_mode <= PMRC_PM_STOP;
				default:
					power_mode <= PMRC_PM_ACTIVE;
			endcase
		end
	end

	// Read data; mode bits always read as zero
	always_ff @(posedge clk)
	begin
		if (rst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd && pmc_hit)
			sfr_rdata <= {general_purpose_flags, 2'b00};
		else
			sfr_rdata <= 8'h00;
	end

	// Core, clock and pin controls derived from sequence and mode
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			core_reset <= 1'b1;
			core_halt <= 1'b1;
			osc_run <= 1'b1;
			periph_run <= 1'b0;
			irq_timer_enable <= 1'b0;
			reset_pin_out <= 1'b0;
			reset_pin_oe <= 1'b1;
			port_latch <= `PMRC_PORT_LATCH_RESET;
			port_open_drain <= 1'b1;
			weak_pullup_en <= 1'b1;
			stack_pointer <= `PMRC_SP_RESET;
			fetch_addr <= `PMRC_PC_RESET;
			sysclk_internal <= 1'b1;
		end
		else
		begin
			core_reset <= in_reset;
			core_halt <= in_reset || (power_mode != PMRC_PM_ACTIVE);
			osc_run <= (power_mode != PMRC_PM_STOP);
			periph_run <= !in_reset && (power_mode != PMRC_PM_STOP);
			irq_timer_enable <= !in_reset;
			reset_pin_out <= 1'b0;
			// Pin driven only for power-on and monitor resets
			reset_pin_oe <= (seq == PMRC_ST_POR) || monitor_reset;
			weak_pullup_en <= 1'b1;
			if (in_reset)
			begin
				port_latch <= `PMRC_PORT_LATCH_RESET;
				port_open_drain <= 1'b1;
				stack_pointer <= `PMRC_SP_RESET;
				fetch_addr <= `PMRC_PC_RESET;
				sysclk_internal <= 1'b1;
			end
		end
	end

	// Watchdog prescaler; data memory is outside and never cleared here
	always_ff @(posedge clk)
	begin
		if (rst || in_reset)
		begin
			wdt_enable <= 1'b1;
			wdt_div_count <= 4'h0;
			wdt_tick <= 1'b0;
		end
		else if (wdt_div_count == 4'(`PMRC_WDT_DIV - 1))
		begin
			wdt_div_count <= 4'h0;
			wdt_tick <= 1'b1;
		end
		else
		begin
			wdt_div_count <= wdt_div_count + 4'h1;
			wdt_tick <= 1'b0;
		end
	end

	a_stop_sticks: assert property (@(posedge clk) disable iff (rst || in_reset)
		power_mode == PMRC_PM_STOP |=> power_mode == PMRC_PM_STOP)
		else $error("stop left without reset");
	a_idle_wake: assert property (@(posedge clk) disable iff (rst || in_reset)
		power_mode == PMRC_PM_IDLE && irq_pending |=> power_mode == PMRC_PM_ACTIVE)
		else $error("idle not ended by interrupt");
	a_mode_bits_zero: assert property (@(posedge clk) disable iff (rst)
		$past(sfr_rd) |-> sfr_rdata[1:0] == 2'b00)
		else $error("mode bits read nonzero");
	a_flags_read: assert property (@(posedge clk) disable iff (rst || in_reset)
		sfr_wr && pmc_hit ##1 sfr_rd && pmc_hit && !sfr_wr |=> sfr_rdata[7:2] == $past(sfr_wdata[7:2], 2))
		else $error("flags not read back");
	a_por_flag_clear: assert property (@(posedge clk) disable iff (rst)
		seq == PMRC_ST_RUN && supply_ok && other_reset |=> !power_on_reset_flag)
		else $error("power-on flag not cleared");
	a_por_flag_set: assert property (@(posedge clk) disable iff (rst)
		seq == PMRC_ST_POR |=> power_on_reset_flag && supply_monitor_en)
		else $error("power-on flag not set");
	a_pin_low_por: assert property (@(posedge clk) disable iff (rst)
		seq == PMRC_ST_POR |=> reset_pin_oe && !reset_pin_out)
		else $error("reset pin not driven");
	a_reset_state: assert property (@(posedge clk) disable iff (rst)
		in_reset |=> fetch_addr == 16'h0000 && port_latch == 8'hff && core_halt)
		else $error("reset state not applied");
	a_wdt_tick: assert property (@(posedge clk) disable iff (rst || in_reset)
		wdt_tick |-> ##12 wdt_tick)
		else $error("watchdog divider wrong");
	a_stop_entry: assert property (@(posedge clk) disable iff (rst || in_reset)
		power_mode == PMRC_PM_ACTIVE && stop_req && instr_done |=> power_mode == PMRC_PM_STOP)
		else $error("stop not entered");
	c_idle: cover property (@(posedge clk) power_mode == PMRC_PM_IDLE ##1 power_mode == PMRC_PM_ACTIVE);
	c_stop: cover property (@(posedge clk) power_mode == PMRC_PM_STOP);
	c_por_release: cover property (@(posedge clk) seq == PMRC_ST_POR ##1 seq == PMRC_ST_RUN);
endmodule // pmrc_power_mode_reset_control
`default_nettype wire

// ===== test/pmrc_power_mode_reset_control_tb_top.sv
// Self-checking bench for the power-mode and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "pmrc_defines.svh"
module pmrc_power_mode_reset_control_tb_top;
	import pmrc_pkg::*;
	// Short power-on delay keeps the run brief
	localparam int unsigned DLY = 8;
	localparam logic [7:0] PMC = `PMRC_ADDR_POWER_MODE_CONTROL;
	logic clk = 1'b0, rst = 1'b1, supply_ok = 1'b1, other_reset = 1'b0, monitor_reset = 1'b0;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, instr_done = 1'b0, irq_pending = 1'b0, rd_d = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, port_latch, stack_pointer, v;
	logic core_halt, core_reset, osc_run, periph_run, irq_timer_enable, reset_pin_out;
	logic reset_pin_oe, port_open_drain, weak_pullup_en, sysclk_internal, wdt_enable, wdt_tick;
	logic power_on_reset_flag, supply_monitor_en;
	logic [15:0] fetch_addr;
	logic [3:0] wdt_div_count;
	pmrc_mode_e power_mode;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	int num_errors = 0, cmp_count = 0, n;
	pmrc_power_mode_reset_control #(.POR_DELAY_CYC(DLY)) u_pmrc_power_mode_reset_control (
		.clk, .rst, .supply_ok, .other_reset, .monitor_reset, .sfr_wr, .sfr_rd, .sfr_addr,
		.sfr_wdata, .instr_done, .irq_pending, .sfr_rdata, .core_halt, .core_reset, .osc_run,
		.periph_run, .irq_timer_enable, .reset_pin_out, .reset_pin_oe, .port_latch,
		.port_open_drain, .weak_pullup_en, .stack_pointer, .fetch_addr, .sysclk_internal,
		.wdt_enable, .wdt_div_count, .wdt_tick, .power_on_reset_flag, .supply_monitor_en,
		.power_mode);
	always #5 clk = ~clk;
	task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask
	task stop_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Read data stands one cycle after the strobe; pair it with the oldest note
	always @(posedge clk)
	begin
		if (rd_d)
			chk_byte("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, sfr_rdata);
		rd_d <= sfr_rd;
	end
	task wr(input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= PMC;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
	endtask
	// Write, then read back on the very next cycle
	task wr_rd(input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= PMC;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
	endtask
	// One completed instruction, then let the mode settle
	task instr;
		@(posedge clk);
		instr_done <= 1'b1;
		@(posedge clk);
		instr_done <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Bounded wait for the core to leave reset; n counts the cycles spent
	task run_wait;
		n = 0;
		while (core_reset !== 1'b0 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		chk_bit("run", 1'b0, core_reset);
	endtask
	initial
	begin
		void'($urandom(32'ha0e3));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk_bit("core_reset", 1'b1, core_reset);
		chk_bit("pin_oe", 1'b1, reset_pin_oe);
		chk_byte("latch", 8'hff, port_latch);
		chk_bit("pullup", 1'b1, weak_pullup_en);
		chk_byte("sp", `PMRC_SP_RESET, stack_pointer);
		chk_bit("fetch", 1'b1, fetch_addr == `PMRC_PC_RESET);
		run_wait();
		chk_bit("delay", 1'b1, n >= DLY);
		chk_bit("por_flag", 1'b1, power_on_reset_flag);
		chk_bit("monitor", 1'b1, supply_monitor_en);
		chk_bit("sysclk", 1'b1, sysclk_internal);
		chk_bit("wdt", 1'b1, wdt_enable);
		rd(PMC, `PMRC_PMC_RESET);
		rd(8'h86, 8'h00);
		// Any 36-cycle span holds exactly three divided ticks
		n = 0;
		repeat (36) @(posedge clk) n += int'(wdt_tick);
		chk_byte("ticks", 8'd3, 8'(n));
		repeat (4)
		begin
			v = 8'($urandom) & 8'hfc;
			wr_rd(v, v);
		end
		wr(8'hb5);
		rd(PMC, 8'hb4);
		instr();
		chk_byte("idle", 8'(PMRC_PM_IDLE), 8'(power_mode));
		chk_bit("halt", 1'b1, core_halt);
		chk_bit("periph", 1'b1, periph_run);
		@(posedge clk);
		irq_pending <= 1'b1;
		repeat (3) @(posedge clk);
		irq_pending <= 1'b0;
		#1;
		chk_byte("wake", 8'(PMRC_PM_ACTIVE), 8'(power_mode));
		rd(PMC, 8'hb4);
		wr(8'h02);
		rd(PMC, 8'h00);
		chk_byte("early", 8'(PMRC_PM_ACTIVE), 8'(power_mode));
		instr();
		chk_byte("stop", 8'(PMRC_PM_STOP), 8'(power_mode));
		chk_bit("osc", 1'b0, osc_run);
		@(posedge clk);
		irq_pending <= 1'b1;
		repeat (3) @(posedge clk);
		irq_pending <= 1'b0;
		other_reset <= 1'b1;
		#1;
		chk_byte("stay", 8'(PMRC_PM_STOP), 8'(power_mode));
		repeat (3) @(posedge clk);
		other_reset <= 1'b0;
		#1;
		chk_bit("por_clr", 1'b0, power_on_reset_flag);
		chk_bit("no_pin", 1'b0, reset_pin_oe);
		run_wait();
		chk_byte("mode", 8'(PMRC_PM_ACTIVE), 8'(power_mode));
		chk_bit("mon_kept", 1'b1, supply_monitor_en);
		@(posedge clk);
		monitor_reset <= 1'b1;
		repeat (3) @(posedge clk);
		monitor_reset <= 1'b0;
		#1;
		chk_bit("mon_pin", 1'b1, reset_pin_oe);
		run_wait();
		// Both mode bits at once: stop takes precedence
		wr(8'h03);
		instr();
		chk_byte("both", 8'(PMRC_PM_STOP), 8'(power_mode));
		@(posedge clk);
		supply_ok <= 1'b0;
		repeat (20) @(posedge clk);
		supply_ok <= 1'b1;
		#1;
		chk_bit("low_supply", 1'b1, core_reset);
		run_wait();
		chk_bit("delay2", 1'b1, n >= DLY);
		chk_bit("por_set", 1'b1, power_on_reset_flag);
		chk_byte("por_mode", 8'(PMRC_PM_ACTIVE), 8'(power_mode));
		stop_test();
	end
	// The whole run is under two hundred cycles; this span is far beyond it
	initial
	begin
		#200000;
		num_errors++;
		stop_test();
	end
endmodule // pmrc_power_mode_reset_control_tb_top
`default_nettype wire
